/* File: wdt_pkg.sv */
package wdt_pkg;

   // Register bus geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;

   // Register byte addresses
   localparam logic [ADDR_W-1:0] MODE_ADDR    = 8'h00;
   localparam logic [ADDR_W-1:0] REFRESH_ADDR = 8'h04;
   localparam logic [ADDR_W-1:0] STATUS_ADDR  = 8'h08;
   localparam logic [ADDR_W-1:0] MASK_ADDR    = 8'h0c;

   // Fixed register values
   localparam logic [DATA_W-1:0] MODE_RESET_VAL   = 8'h67;
   localparam logic [DATA_W-1:0] MODE_STOP_VAL    = 8'h1f;
   localparam logic [DATA_W-1:0] REFRESH_KEY      = 8'hac;
   localparam logic [DATA_W-1:0] REFRESH_READ_VAL = 8'h9a;
   localparam logic [DATA_W-1:0] UNMAPPED_VAL     = 8'h00;

   // Mode register field layout
   localparam int ACT_MSB      = 6;
   localparam int ACT_LSB      = 5;
   localparam int SEL_STOP_BIT = 4;
   localparam int SEL_SUB_BIT  = 3;
   localparam int SEL_EXP_MSB  = 2;
   localparam logic [1:0] ACT_RESET = 2'b11;

   // Interval exponents for select code zero
   localparam int MAIN_EXP_DEF = 18;
   localparam int SUB_EXP_DEF  = 9;
   localparam int EXP_W        = 5;
   localparam int CNT_W_DEF    = 26;

   // Status and mask layout
   localparam int STAT_W      = 2;
   localparam int ST_OVF_BIT  = 0;
   localparam int ST_ILL_BIT  = 1;
   localparam logic [STAT_W-1:0] STAT_RESET_VAL = 2'h0;

   typedef enum logic [0:0] {
      ST_DEFAULT = 1'b0,
      ST_LOCKED  = 1'b1
   } wdt_state_t;

   typedef struct packed {
      wdt_state_t        state;
      logic [DATA_W-1:0] mode;
      logic [DATA_W-1:0] rdata;
      logic [STAT_W-1:0] status;
      logic [STAT_W-1:0] mask;
      logic              rst_req;
      logic              nmi_req;
      logic              irq;
   } wdt_regs_t;

endpackage : wdt_pkg

/* File: wdt_counter.sv */
`timescale 1ns/100ps

module wdt_counter
   import wdt_pkg::*;
#(
   parameter int CNT_W = CNT_W_DEF
)(
   input  wire logic             sys_clk,  // System clock
   input  wire logic             resetn,   // Async reset, active low
   input  wire logic             run,      // Counting allowed
   input  wire logic             tick,     // One count step this cycle
   input  wire logic             clear,    // Restart from zero
   input  wire logic [EXP_W-1:0] exp,      // Interval is 2**exp steps
   output logic                  expire,   // Interval elapsed, comb
   output logic [CNT_W-1:0]      count     // Current count
);

   typedef struct packed {
      logic [CNT_W-1:0] count;
   } cnt_state_t;

   cnt_state_t       cur;
   cnt_state_t       nxt;
   logic [CNT_W-1:0] term;

   // Last count value of the selected interval
   assign term  = (CNT_W'(1) << exp) - CNT_W'(1);
   assign count = cur.count;

   // Clear has priority so a refresh never races an expiry step
   always_comb begin
      nxt    = cur;
      expire = 1'b0;
      if (clear) begin
         nxt.count = '0;
      end else if (run && tick) begin
         if (cur.count >= term) begin
            expire    = 1'b1;
            nxt.count = '0;
         end else begin
            nxt.count = cur.count + CNT_W'(1);
         end
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         cur <= '0;
      end else begin
         cur <= nxt;
      end
   end

   property p_clear_zero;
      @(posedge sys_clk) disable iff (!resetn)
      clear |=> (count == '0);
   endproperty
   a_clear_zero: assert property (p_clear_zero)
      else $error("counter not zero after clear");

endmodule : wdt_counter

/* File: wdt_top.sv */
// Behaviour
// - Counting starts by itself in reset mode once reset is released.
// - Mode register reads 67h after reset: reset action, longest main interval.
// - Mode register takes one write per reset, then holds; reads unlimited.
// - A second mode write forces an overflow at once.
// - Writing 1Fh as the single mode write stops the watchdog.
// - Select 0xxx main 2^18..2^25, 1xxx sub 2^9..2^16, top bit stops.
// - After a valid mode write software cannot stop the watchdog.
// - Writing ACh to the refresh register restarts the count from zero.
// - Writing any other byte to the refresh register forces an overflow.
// - Single-bit access to the refresh register forces an overflow.
// - Refresh register always reads 9Ah.
// - Overflow raises system reset or NMI request per action select bits.
`timescale 1ns/100ps

module wdt_top
   import wdt_pkg::*;
#(
   parameter int MAIN_EXP = MAIN_EXP_DEF, // Exponent for main select 000
   parameter int SUB_EXP  = SUB_EXP_DEF,  // Exponent for sub select 000
   parameter int CNT_W    = CNT_W_DEF     // Counter width
)(
   input  wire logic              sys_clk,           // 25 MHz system clock
   input  wire logic              resetn,            // Async reset, low
   input  wire logic [ADDR_W-1:0] addr,              // Register address
   input  wire logic [DATA_W-1:0] wdata,             // Write data
   input  wire logic              wr_en,             // Write strobe
   input  wire logic              rd_en,             // Read strobe
   input  wire logic              bit_access,        // Write is single-bit
   input  wire logic              sub_tick,          // Subclock edge pulse
   output logic [DATA_W-1:0]      rdata,             // Read data, next cycle
   output logic                   wdt_reset_request, // Overflow reset pulse
   output logic                   wdt_nmi_request,   // Overflow NMI pulse
   output logic                   irq                // Level interrupt
);

   wdt_regs_t        cur;
   wdt_regs_t        nxt;
   logic             expire;
   logic [CNT_W-1:0] count;
   logic             cnt_run;
   logic             cnt_tick;
   logic             cnt_clear;
   logic [EXP_W-1:0] cnt_exp;
   logic             mode_wr;
   logic             refresh_wr;
   logic             refresh_ok;
   logic             first_mode_wr;
   logic             illegal;
   logic             ovf_event;
   logic [STAT_W-1:0] stat_set;
   logic [STAT_W-1:0] stat_clr;

   // Address match, shared by the read and write decoders
   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [ADDR_W-1:0] off);
      hit = (a == off);
   endfunction : hit

   // Interval exponent from the clock select field
   function automatic logic [EXP_W-1:0] sel_exp(input logic [DATA_W-1:0] m);
      logic [EXP_W-1:0] base;
      base = m[SEL_SUB_BIT] ? EXP_W'(SUB_EXP) : EXP_W'(MAIN_EXP);
      sel_exp = base + EXP_W'(m[SEL_EXP_MSB:0]);
   endfunction : sel_exp

   // Write decode and legality checks
   assign mode_wr       = wr_en && hit(addr, MODE_ADDR);
   assign refresh_wr    = wr_en && hit(addr, REFRESH_ADDR);
   assign first_mode_wr = mode_wr && (cur.state == ST_DEFAULT);
   assign refresh_ok    = refresh_wr && !bit_access
                          && (wdata == REFRESH_KEY);
   assign illegal = (mode_wr && (cur.state == ST_LOCKED))
                  || (refresh_wr && (wdata != REFRESH_KEY))
                  || (refresh_wr && bit_access);

   // Counter control; runs from reset on the default mode value
   assign cnt_run   = !cur.mode[SEL_STOP_BIT];
   assign cnt_tick  = cur.mode[SEL_SUB_BIT] ? sub_tick : 1'b1;
   assign cnt_exp   = sel_exp(cur.mode);
   // A new mode or a forced overflow also restarts the interval
   assign cnt_clear = refresh_ok || first_mode_wr || illegal;
   assign ovf_event = expire || illegal;

   wdt_counter #(
      .CNT_W (CNT_W)
   ) u_counter (
      .sys_clk (sys_clk),
      .resetn  (resetn),
      .run     (cnt_run),
      .tick    (cnt_tick),
      .clear   (cnt_clear),
      .exp     (cnt_exp),
      .expire  (expire),
      .count   (count)
   );

   // Interrupt events: set wins over a write-one clear
   always_comb begin
      stat_set = '0;
      stat_set[ST_OVF_BIT] = ovf_event;
      stat_set[ST_ILL_BIT] = illegal;
      stat_clr = (wr_en && hit(addr, STATUS_ADDR)) ? wdata[STAT_W-1:0] : '0;
   end

   // Next state of every register of the block
   always_comb begin
      nxt = cur;
      case (cur.state)
         ST_DEFAULT: begin
            if (mode_wr) begin
               nxt.mode  = wdata;
               nxt.state = ST_LOCKED;
            end
         end
         ST_LOCKED: begin
            nxt.mode = cur.mode;
         end
         default: begin
            nxt.state = ST_DEFAULT;
         end
      endcase
      if (wr_en && hit(addr, MASK_ADDR)) begin
         nxt.mask = wdata[STAT_W-1:0];
      end
      nxt.status = (cur.status & ~stat_clr) | stat_set;
      nxt.irq    = |(nxt.status & nxt.mask);
      // Same overflow path for expiry and illegal access
      nxt.rst_req = ovf_event
                    && (cur.mode[ACT_MSB:ACT_LSB] == ACT_RESET);
      nxt.nmi_req = ovf_event
                    && (cur.mode[ACT_MSB:ACT_LSB] != ACT_RESET);
      // Read data live for one cycle only, zero otherwise
      nxt.rdata = UNMAPPED_VAL;
      if (rd_en) begin
         if (hit(addr, MODE_ADDR)) begin
            nxt.rdata = cur.mode;
         end else if (hit(addr, REFRESH_ADDR)) begin
            nxt.rdata = REFRESH_READ_VAL;
         end else if (hit(addr, STATUS_ADDR)) begin
            nxt.rdata = DATA_W'(cur.status);
         end else if (hit(addr, MASK_ADDR)) begin
            nxt.rdata = DATA_W'(cur.mask);
         end
      end
   end

   // State register; mode comes up at its reset-action default
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         cur.state   <= ST_DEFAULT;
         cur.mode    <= MODE_RESET_VAL;
         cur.rdata   <= UNMAPPED_VAL;
         cur.status  <= STAT_RESET_VAL;
         cur.mask    <= STAT_RESET_VAL;
         cur.rst_req <= 1'b0;
         cur.nmi_req <= 1'b0;
         cur.irq     <= 1'b0;
      end else begin
         cur <= nxt;
      end
   end

   // Outputs straight from flip-flops
   assign rdata             = cur.rdata;
   assign wdt_reset_request = cur.rst_req;
   assign wdt_nmi_request   = cur.nmi_req;
   assign irq               = cur.irq;

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!resetn);

   sequence s_second_mode_wr;
      (cur.state == ST_LOCKED) && mode_wr;
   endsequence

   sequence s_bad_key;
      refresh_wr && !bit_access && (wdata != REFRESH_KEY);
   endsequence

   sequence s_overflow_out;
      wdt_reset_request || wdt_nmi_request;
   endsequence

   property p_default_mode;
      (cur.state == ST_DEFAULT) |-> (cur.mode == MODE_RESET_VAL) && cnt_run;
   endproperty
   a_default_mode: assert property (p_default_mode)
      else $error("default mode not reset value or not running");

   property p_read_mode;
      rd_en && hit(addr, MODE_ADDR) && !mode_wr |=> (rdata == $past(cur.mode));
   endproperty
   a_read_mode: assert property (p_read_mode)
      else $error("mode read data wrong");

   property p_mode_hold;
      (cur.state == ST_LOCKED) ##1 (cur.state == ST_LOCKED)
         |-> $stable(cur.mode);
   endproperty
   a_mode_hold: assert property (p_mode_hold)
      else $error("locked mode register changed");

   property p_second_write;
      s_second_mode_wr |=> s_overflow_out;
   endproperty
   a_second_write: assert property (p_second_write)
      else $error("second mode write gave no overflow");

   property p_stop_value;
      first_mode_wr && (wdata == MODE_STOP_VAL) |=> !cnt_run [*8];
   endproperty
   a_stop_value: assert property (p_stop_value)
      else $error("stop value did not stop counter");

   property p_bad_key;
      s_bad_key |=> s_overflow_out;
   endproperty
   a_bad_key: assert property (p_bad_key)
      else $error("wrong key gave no overflow");

   property p_bit_access;
      refresh_wr && bit_access |=> s_overflow_out;
   endproperty
   a_bit_access: assert property (p_bit_access)
      else $error("bit access gave no overflow");

   property p_refresh_read;
      rd_en && hit(addr, REFRESH_ADDR) |=> (rdata == REFRESH_READ_VAL);
   endproperty
   a_refresh_read: assert property (p_refresh_read)
      else $error("refresh register read not fixed value");

   property p_action;
      ovf_event |=> (wdt_reset_request
                     == ($past(cur.mode[ACT_MSB:ACT_LSB]) == ACT_RESET))
                    && (wdt_nmi_request != wdt_reset_request);
   endproperty
   a_action: assert property (p_action)
      else $error("overflow action does not match mode");

   property p_good_key;
      refresh_ok && !illegal |=> (count == '0) && !wdt_reset_request
                                 && !wdt_nmi_request;
   endproperty
   a_good_key: assert property (p_good_key)
      else $error("good key did not restart count quietly");

   property p_irq;
      ##1 (irq == |(cur.status & cur.mask));
   endproperty
   a_irq: assert property (p_irq)
      else $error("interrupt level disagrees with status and mask");

   // Checks on locking, forced overflow and idle outputs
   property p_req_cause;
      s_overflow_out |-> $past(ovf_event);
   endproperty
   a_req_cause: assert property (p_req_cause)
      else $error("request without an overflow event");

   property p_forced_clear;
      illegal |=> (count == '0);
   endproperty
   a_forced_clear: assert property (p_forced_clear)
      else $error("forced overflow did not restart the count");

   property p_stop_quiet;
      cur.mode[SEL_STOP_BIT] |-> !expire;
   endproperty
   a_stop_quiet: assert property (p_stop_quiet)
      else $error("stopped watchdog reached expiry");

   property p_lock_kept;
      (cur.state == ST_LOCKED) |=> (cur.state == ST_LOCKED);
   endproperty
   a_lock_kept: assert property (p_lock_kept)
      else $error("locked state left without reset");

   property p_first_store;
      first_mode_wr |=> (cur.mode == $past(wdata))
                        && (cur.state == ST_LOCKED);
   endproperty
   a_first_store: assert property (p_first_store)
      else $error("first mode write not stored");

   property p_status_set;
      ovf_event |=> cur.status[ST_OVF_BIT];
   endproperty
   a_status_set: assert property (p_status_set)
      else $error("overflow did not set its status bit");

   // A clear with no event in the same cycle must take effect
   property p_status_clear;
      wr_en && hit(addr, STATUS_ADDR) && wdata[ST_ILL_BIT] && !illegal
         |=> !cur.status[ST_ILL_BIT];
   endproperty
   a_status_clear: assert property (p_status_clear)
      else $error("write-one clear did not clear status");

   property p_rdata_idle;
      !rd_en |=> (rdata == UNMAPPED_VAL);
   endproperty
   a_rdata_idle: assert property (p_rdata_idle)
      else $error("read data not idle outside a read");

endmodule : wdt_top

/* File: wdt_sys_model.sv */
`timescale 1ns/100ps

module wdt_sys_model #(
   parameter int TICK_DIV = 8              // System cycles per subclock
)(
   input  wire logic       sys_clk,           // System clock
   input  wire logic       resetn,            // Async reset, active low
   input  wire logic       wdt_reset_request, // Overflow reset pulse
   input  wire logic       wdt_nmi_request,   // Overflow NMI pulse
   output logic            sub_tick,          // Subclock edge pulse
   output logic [7:0]      rst_seen,          // Reset pulses counted
   output logic [7:0]      nmi_seen           // NMI pulses counted
);
   int div;

   // Subclock runs free; the reset and NMI sinks only count pulses
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         div      <= 0;
         sub_tick <= 1'b0;
         rst_seen <= 8'h00;
         nmi_seen <= 8'h00;
      end else begin
         div      <= (div == TICK_DIV - 1) ? 0 : div + 1;
         sub_tick <= (div == TICK_DIV - 1);
         rst_seen <= rst_seen + {7'h00, wdt_reset_request};
         nmi_seen <= nmi_seen + {7'h00, wdt_nmi_request};
      end
   end

endmodule : wdt_sys_model

/* File: wdt_top_tb.sv */
`timescale 1ns/100ps

module wdt_top_tb
   import wdt_pkg::*;
;
   // Short exponents keep the default interval at 2**9 cycles
   localparam int MEXP = 2;
   localparam int SEXP = 1;
   logic              sys_clk;
   logic              resetn;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata;
   logic              wr_en;
   logic              rd_en;
   logic              bit_access;
   logic              sub_tick;
   logic [DATA_W-1:0] rdata;
   logic              rst_req;
   logic              nmi_req;
   logic              irq;
   logic [7:0]        rst_seen;
   logic [7:0]        nmi_seen;
   logic [7:0]        seen;
   int                err_count;
   int                n_checks;
   int                n;

   wdt_top #(.MAIN_EXP(MEXP), .SUB_EXP(SEXP)) u_dut (
      .sys_clk(sys_clk), .resetn(resetn), .addr(addr), .wdata(wdata),
      .wr_en(wr_en), .rd_en(rd_en), .bit_access(bit_access),
      .sub_tick(sub_tick), .rdata(rdata), .wdt_reset_request(rst_req),
      .wdt_nmi_request(nmi_req), .irq(irq));

   wdt_sys_model #(.TICK_DIV(8)) u_sys (
      .sys_clk(sys_clk), .resetn(resetn), .wdt_reset_request(rst_req),
      .wdt_nmi_request(nmi_req), .sub_tick(sub_tick),
      .rst_seen(rst_seen), .nmi_seen(nmi_seen));

   // 25 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   task automatic report_and_stop();
      $display("Checks %0d, mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : report_and_stop

   task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check_val

   task automatic check_rng(input int got, input int lo, input int hi);
      n_checks++;
      if (got < lo || got > hi) begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
      end
   endtask : check_rng

   task automatic do_reset();
      @(posedge sys_clk);
      resetn <= 1'b0;
      repeat (16) @(posedge sys_clk);
      resetn <= 1'b1;
   endtask : do_reset

   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic b);
      @(posedge sys_clk);
      addr       <= a;
      wdata      <= d;
      bit_access <= b;
      wr_en      <= 1'b1;
      @(posedge sys_clk);
      wr_en      <= 1'b0;
      bit_access <= 1'b0;
   endtask : wr

   // Read data stand only in the cycle after the strobe
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      @(posedge sys_clk);
      addr  <= a;
      rd_en <= 1'b1;
      @(posedge sys_clk);
      rd_en <= 1'b0;
      #1;
      check_val(rdata, e);
   endtask : rd_chk

   // Cycles until either request; n = 0 means already high
   task automatic wait_req(input int bound);
      n = 0;
      #1;
      while (rst_req !== 1'b1 && nmi_req !== 1'b1) begin
         if (n == bound) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, 0, 1);
            report_and_stop();
         end
         @(posedge sys_clk);
         #1;
         n++;
      end
   endtask : wait_req

   task automatic t_defaults();
      rd_chk(MODE_ADDR, 8'h67);
      rd_chk(REFRESH_ADDR, 8'h9a);
      rd_chk(STATUS_ADDR, 8'h00);
      rd_chk(8'h10, 8'h00);
      wait_req(600);
      check_val({7'h00, rst_req}, 8'h01);
      wr(REFRESH_ADDR, REFRESH_KEY, 1'b0);
      wait_req(600);
      check_rng(n, 511, 513);
      check_val({7'h00, rst_req}, 8'h01);
   endtask : t_defaults

   task automatic t_nmi_once();
      do_reset();
      wr(MODE_ADDR, 8'h00, 1'b0);
      rd_chk(MODE_ADDR, 8'h00);
      wait_req(8);
      check_val({6'h00, rst_req, nmi_req}, 8'h01);
      wr(MODE_ADDR, MODE_STOP_VAL, 1'b0);
      wait_req(1);
      check_rng(n, 0, 0);
      check_val({6'h00, rst_req, nmi_req}, 8'h01);
      rd_chk(MODE_ADDR, 8'h00);
      wait_req(8);
      check_rng(n, 0, 6);
   endtask : t_nmi_once

   // Both stop encodings: the stop byte and a clock select with bit 4 set
   task automatic t_stop(input logic [7:0] v);
      do_reset();
      wr(MODE_ADDR, v, 1'b0);
      seen = rst_seen + nmi_seen;
      // Outlasts the subclock interval 1Fh would give if stop failed
      repeat (2100) @(posedge sys_clk);
      check_val(rst_seen + nmi_seen, seen);
      wr(REFRESH_ADDR, 8'h55, 1'b0);
      wait_req(1);
      check_rng(n, 0, 0);
      check_val({7'h00, rst_req}, {7'h00, v[6:5] == ACT_RESET});
   endtask : t_stop

   task automatic t_irq();
      do_reset();
      wr(MASK_ADDR, 8'h03, 1'b0);
      wr(REFRESH_ADDR, REFRESH_KEY, 1'b1);
      wait_req(1);
      check_rng(n, 0, 0);
      check_val({7'h00, irq}, 8'h01);
      @(posedge sys_clk);
      #1;
      check_val({6'h00, rst_req, nmi_req}, 8'h00);
      rd_chk(STATUS_ADDR, 8'h03);
      wr(STATUS_ADDR, 8'h03, 1'b0);
      rd_chk(STATUS_ADDR, 8'h00);
      check_val({7'h00, irq}, 8'h00);
      wr(MASK_ADDR, 8'h00, 1'b0);
      wr(REFRESH_ADDR, 8'h55, 1'b0);
      rd_chk(STATUS_ADDR, 8'h03);
      check_val({7'h00, irq}, 8'h00);
   endtask : t_irq

   // Subclock select: two ticks of eight cycles, slower than main code 0
   task automatic t_sub();
      do_reset();
      wr(MODE_ADDR, 8'h08, 1'b0);
      wait_req(40);
      check_rng(n, 8, 25);
      check_val({6'h00, rst_req, nmi_req}, 8'h01);
   endtask : t_sub

   initial begin
      resetn     = 1'b0;
      addr       = 8'h00;
      wdata      = 8'h00;
      wr_en      = 1'b0;
      rd_en      = 1'b0;
      bit_access = 1'b0;
      err_count  = 0;
      n_checks   = 0;
      do_reset();
      t_defaults();
      t_nmi_once();
      t_stop(MODE_STOP_VAL);
      t_stop(8'h70);
      t_irq();
      t_sub();
      report_and_stop();
   end

endmodule : wdt_top_tb
